/* File: design/pciarb_pins.sv */
// Arbitration and interrupt pin logic of the bus controller.
// Assumes pins are sampled on sys_clk, the bus clock, by two flip-flops.
//
// Overview of operation
// - Each attached agent has its own request input asking for the bus.
// - Arbiter on: shared request pin is an input, one more agent request.
// - Arbiter off: shared request pin is driven to ask external arbiter.
// - Arbiter drives a grant output to each agent to permit bus control.
// - Arbiter on: shared grant pin is driven for the shared-pin agent.
// - Arbiter off: shared grant is an input; take bus only once granted.
// - Interrupt pin is open drain: pulled low to signal, never high.
// - Arbitration signals are sampled on the rising bus clock edge.
`timescale 1ns/1ns
`include "pciarb_map.svh"
module pciarb_pins #(
    parameter int NUM_AGENTS = `PCIARB_NUM_AGENTS
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ifEnable,
    input wire logic arbEnable,
    input wire logic [NUM_AGENTS-1:0] agentReq_n,
    output logic [NUM_AGENTS-1:0] agentGnt_n,
    output logic [NUM_AGENTS-1:0] agentGntOe_n,
    input wire logic sharedReqIn_n,
    output logic sharedReqOut_n,
    output logic sharedReqOe_n,
    input wire logic sharedGntIn_n,
    output logic sharedGntOut_n,
    output logic sharedGntOe_n,
    input wire logic ownReq,
    input wire logic ownDone,
    output logic ownGranted,
    input wire logic intReq,
    output logic intOut_n,
    output logic intOe_n
);
    import pciarb_pkg::*;

    localparam int NREQ = NUM_AGENTS + 1;

    // Idle level of one grant line, spread over all agents
    localparam logic [NUM_AGENTS-1:0] GNT_IDLE =
        {NUM_AGENTS{`PCIARB_GRANT_IDLE_BIT}};

    typedef struct packed {
        // Pin samplers, first and second stage
        logic [NUM_AGENTS-1:0] reqMeta;
        logic [NUM_AGENTS-1:0] reqSync;
        logic [1:0] sReqMeta;
        logic [1:0] sReqSync;

        // Arbiter state and ownership
        pciarb_state_t state;
        logic [NREQ-1:0] owner;
        logic [NREQ-1:0] lastOwner;

        // Registered pin drivers
        logic [NUM_AGENTS-1:0] agentGnt_n;
        logic [NUM_AGENTS-1:0] agentGntOe_n;
        logic sharedReqOut_n;
        logic sharedReqOe_n;
        logic sharedGntOut_n;
        logic sharedGntOe_n;
        logic ownGranted;
        logic intOut_n;
        logic intOe_n;
    } pciarb_regs_t;

    pciarb_regs_t r;
    pciarb_regs_t next_r;
    logic [NREQ-1:0] reqVec;
    logic [NREQ-1:0] pick;
    logic [NREQ-1:0] aboveLast;
    logic sharedReqSync;
    logic sharedGntSync;

    // Requesters past the last owner get first pick; this rotates the bus
    for (genvar g = 0; g < NREQ; g++) begin : g_above
        assign aboveLast[g] = (r.lastOwner >> g) == '0;
    end

    always_comb begin
        // Synchronised copies of the shared pins
        sharedReqSync = r.sReqSync[0];
        sharedGntSync = r.sReqSync[1];

        // Shared request only counts while the arbiter is on
        reqVec = {~sharedReqSync & arbEnable, ~r.reqSync};

        // First pass: lowest request above the last owner
        pick = '0;
        for (int i = 0; i < NREQ; i++) begin
            if (pick == '0 && reqVec[i] && aboveLast[i]) begin
                pick[i] = 1'b1;
            end
        end

        // Second pass: wrap round to the lowest request
        if (pick == '0) begin
            for (int i = 0; i < NREQ; i++) begin
                if (pick == '0 && reqVec[i]) begin
                    pick[i] = 1'b1;
                end
            end
        end

        next_r = r;

        // Two-stage sampling of pins on the rising bus clock edge
        next_r.reqMeta = agentReq_n;
        next_r.reqSync = r.reqMeta;
        next_r.sReqMeta = {sharedGntIn_n, sharedReqIn_n};
        next_r.sReqSync = r.sReqMeta;

        // Pin directions follow the enables
        next_r.agentGntOe_n = {NUM_AGENTS{~ifEnable}};
        next_r.sharedGntOe_n = ~(ifEnable & arbEnable);
        next_r.sharedReqOe_n = ~(ifEnable & ~arbEnable);

        // Open drain: only ever pulls low, released otherwise
        next_r.intOut_n = 1'b0;
        next_r.intOe_n = ~(ifEnable & intReq);

        // Grants and requests idle unless a state drives them
        next_r.agentGnt_n = GNT_IDLE;
        next_r.sharedGntOut_n = 1'b1;
        next_r.sharedReqOut_n = 1'b1;
        next_r.ownGranted = 1'b0;

        case (r.state)
            ST_OFF: begin
                // Pins float; wait for software
                next_r.owner = '0;
                if (ifEnable) begin
                    next_r.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // One idle cycle between owners
                next_r.owner = '0;
                if (!ifEnable) begin
                    next_r.state = ST_OFF;
                end else if (arbEnable && pick != '0) begin
                    next_r.owner = pick;
                    next_r.lastOwner = pick;
                    next_r.state = ST_GRANT;
                end else if (!arbEnable && ownReq) begin
                    next_r.sharedReqOut_n = 1'b0;
                    next_r.state = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (!ifEnable) begin
                    next_r.state = ST_OFF;
                end else if (arbEnable) begin
                    // Hold grant while the owner keeps requesting
                    if ((r.owner & reqVec) != '0) begin
                        next_r.agentGnt_n =
                            ~r.owner[NUM_AGENTS-1:0];
                        next_r.sharedGntOut_n =
                            ~r.owner[NUM_AGENTS];
                    end else begin
                        next_r.state = ST_IDLE;
                    end
                end else if (ownReq && !ownDone) begin
                    // Keep asking; use the bus only once granted
                    next_r.sharedReqOut_n = 1'b0;
                    next_r.ownGranted = ~sharedGntSync;
                end else begin
                    next_r.state = ST_IDLE;
                end
            end
            default: begin
                next_r.state = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.reqMeta <= '1;
            r.reqSync <= '1;
            r.sReqMeta <= 2'h3;
            r.sReqSync <= 2'h3;
            r.state <= ST_OFF;
            r.agentGnt_n <= GNT_IDLE;
            r.agentGntOe_n <= '1;
            r.sharedReqOut_n <= 1'b1;
            r.sharedReqOe_n <= 1'b1;
            r.sharedGntOut_n <= 1'b1;
            r.sharedGntOe_n <= 1'b1;
            r.intOut_n <= 1'b0;
            r.intOe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Every output comes straight from a register
    assign agentGnt_n = r.agentGnt_n;
    assign agentGntOe_n = r.agentGntOe_n;
    assign sharedReqOut_n = r.sharedReqOut_n;
    assign sharedReqOe_n = r.sharedReqOe_n;
    assign sharedGntOut_n = r.sharedGntOut_n;
    assign sharedGntOe_n = r.sharedGntOe_n;
    assign ownGranted = r.ownGranted;
    assign intOut_n = r.intOut_n;
    assign intOe_n = r.intOe_n;
endmodule : pciarb_pins

/* File: design/pciarb_map.svh */
// Constants for the arbitration pin block: counts and reset values.
// Assumes inclusion by the package and the design module only.
`ifndef PCIARB_MAP_SVH
`define PCIARB_MAP_SVH
`define PCIARB_NUM_AGENTS 4
`define PCIARB_GRANT_IDLE 4'hF
`define PCIARB_GRANT_IDLE_BIT 1'b1
`define PCIARB_BUS_MHZ 33
`endif

/* File: design/pciarb_pkg.sv */
// Types for the arbitration pin block.
// Assumes pciarb_map.svh is on the include path.
`include "pciarb_map.svh"
package pciarb_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_IDLE = 3'h2,
        ST_GRANT = 3'h4
    } pciarb_state_t;
    typedef logic [`PCIARB_NUM_AGENTS-1:0] pciarb_vec_t;
endpackage : pciarb_pkg

/* File: verif/pciarb_props.sv */
// Checker on the arbitration pin ports.
// Bound into pciarb_pins; sees its ports only.
`timescale 1ns/1ns
module pciarb_props #(parameter int NUM_AGENTS = 4) (
    input wire logic sys_clk, arst_n, ifEnable, arbEnable, intReq,
    input wire logic [NUM_AGENTS-1:0] agentReq_n, agentGnt_n,
    input wire logic sharedReqOe_n, sharedGntIn_n, sharedGntOut_n,
    input wire logic sharedGntOe_n, ownGranted, intOut_n, intOe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_high6(x); x [*6]; endsequence
    a_int_low: assert property (!intOut_n) else $error("int high");
    a_int_pull: assert property (
        (ifEnable && intReq) [*2] |-> !intOe_n) else $error("int idle");
    a_pins_float: assert property (
        (!ifEnable) [*2] |-> sharedReqOe_n && sharedGntOe_n && intOe_n)
        else $error("pin driven");
    a_one_grant: assert property (
        $onehot0({~agentGnt_n, ~(sharedGntOut_n | sharedGntOe_n)}))
        else $error("two grants");
    a_idle_agent: assert property (
        s_high6(agentReq_n[0]) |-> agentGnt_n[0]) else $error("stray grant");
    a_share_on: assert property (
        (ifEnable && arbEnable) [*3] |-> sharedReqOe_n && !sharedGntOe_n)
        else $error("shared on");
    a_share_off: assert property (
        (ifEnable && !arbEnable) [*3] |-> !sharedReqOe_n && sharedGntOe_n)
        else $error("shared off");
    a_own_waits: assert property (
        s_high6(sharedGntIn_n) |-> !ownGranted) else $error("own early");
endmodule : pciarb_props
bind pciarb_pins pciarb_props #(.NUM_AGENTS(NUM_AGENTS)) u_props (.*);

/* File: verif/pciarb_ext_arb.sv */
// External arbiter model for the shared request pin.
// Assumes a released request pin reads high.
`timescale 1ns/1ns
module pciarb_ext_arb (
    input wire logic sys_clk, req_n,
    input wire logic [3:0] lag,
    output logic gnt_n = 1'h1
);
    logic [3:0] waited = 4'h0;
    always @(posedge sys_clk) begin
        waited <= req_n ? 4'h0 : waited + {3'h0, waited != 4'hF};
        gnt_n <= req_n || waited < lag;
    end
endmodule : pciarb_ext_arb

/* File: verif/pciarb_pins_tb_top.sv */
// Bench for the arbitration pin block and an external arbiter.
// Checker binds itself; inputs change on the falling edge.
`timescale 1ns/1ns
module pciarb_pins_tb_top;
    import pciarb_pkg::*;
    logic sys_clk = 1'h0, arst_n = 1'h0, ifEnable = 1'h0, arbEnable = 1'h1;
    logic intReq = 1'h0, shReq_n = 1'h1, ownReq = 1'h0, ownDone = 1'h0;
    logic sharedReqOut_n, sharedReqOe_n, sharedGntOut_n, sharedGntOe_n;
    logic ownGranted, intOut_n, intOe_n, extGnt_n;
    logic [3:0] lag = 4'h6;
    pciarb_vec_t agentReq_n = 4'hF, agentGnt_n, agentGntOe_n;
    logic [9:0] rows [6] = '{10'h3BD, 10'h37B, 10'h2F7, 10'h1EF,
        10'h3DE, 10'h3FF};
    int badCount = 0, comparisons = 0, cycles = 0;
    wire logic reqW_n = sharedReqOe_n ? shReq_n : sharedReqOut_n;
    wire logic gntW_n = sharedGntOe_n ? extGnt_n : sharedGntOut_n;
    wire logic [1:0] reqPin = {sharedReqOe_n, sharedReqOut_n};
    wire logic [4:0] grants = {agentGnt_n, sharedGntOut_n};
    wire logic [6:0] flt = {agentGntOe_n, sharedReqOe_n, sharedGntOe_n,
        intOe_n};
    pciarb_pins u_dut (.sharedReqIn_n(reqW_n), .sharedGntIn_n(gntW_n), .*);
    pciarb_ext_arb u_ext (.sys_clk(sys_clk), .req_n(reqW_n), .lag(lag),
        .gnt_n(extGnt_n));
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 900) badCount++;
        if (cycles == 900) finalReport();
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finalReport();
        $display("compares %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finalReport
    initial begin
        tick(5);
        ifEnable = 1'h1;
        intReq = 1'h1;
        tick(5);
        chk({flt, ownGranted}, 10'h0FE);
        arst_n = 1'h1;
        intReq = 1'h0;
        $display("reset done");
        foreach (rows[i]) begin
            {agentReq_n, shReq_n} = rows[i][9:5];
            tick(12);
            chk(grants, rows[i][4:0]);
        end
        $display("grant rows done");
        intReq = 1'h1;
        tick(3);
        chk({intOut_n, intOe_n}, 10'h000);
        ifEnable = 1'h0;
        tick(3);
        chk(flt, 10'h07F);
        ifEnable = 1'h1;
        intReq = 1'h0;
        $display("interrupt done");
        arbEnable = 1'h0;
        repeat (2) begin
            ownReq = 1'h1;
            ownDone = 1'h0;
            tick(6);
            chk({reqPin, ownGranted & |lag}, 10'h000);
            for (int i = 0; i < 30 && ownGranted !== 1'h1; i++)
                tick(1);
            chk(ownGranted, 10'h001);
            ownReq = 1'h0;
            ownDone = 1'h1;
            tick(6);
            chk({reqPin, ownGranted}, 10'h002);
            lag = 4'h0;
        end
        $display("external arbiter done");
        finalReport();
    end
endmodule : pciarb_pins_tb_top
